/* File: hw/cgl_pkg.sv */
// Constants, types and field layouts of the configuration and drive-rate glue.
package cgl_pkg;

  // Host I/O port addresses.
  localparam logic [15:0] CFG_PORT_ADDR = 16'h03F0;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h03F1;
  localparam logic [15:0] SHARED_ADDR = 16'h03F7;

  // Key, exit and reset filter values; the key byte is arbitrary.
  localparam logic [7:0] KEY_BYTE = 8'h55;
  localparam logic [3:0] KEY_LEN = 4'h2;
  localparam logic [7:0] EXIT_BYTE = 8'hAA;
  localparam logic [7:0] RESET_FILT_CYCLES = 8'h08;

  // Configuration register indices.
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ = 8'h70;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_FDC_OPT = 8'hF0;
  localparam logic [7:0] IDX_DRIVE0_RATE_TYPE_CFG = 8'hF4;
  localparam logic [7:0] IDX_DRIVE1_RATE_TYPE_CFG = 8'hF5;

  // Logical device numbers.
  localparam logic [7:0] LDN_FDC = 8'h00;
  localparam logic [7:0] LDN_LPT = 8'h03;
  localparam logic [7:0] LDN_UART1 = 8'h04;
  localparam logic [7:0] LDN_UART2 = 8'h05;

  // Drive and FDC option register field positions.
  localparam int DRV_PRECOMP_BIT = 6;
  localparam int DRV_TABLE_HI_BIT = 4;
  localparam int DRV_TABLE_LO_BIT = 3;
  localparam int DRV_TYPE_A_BIT = 1;
  localparam int DRV_TYPE_B_BIT = 0;
  localparam int FDC_OPT_BURST_BIT = 1;

  // Reset values.
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [2:0] DMA_NONE = 3'h4;
  localparam logic [15:0] BASE_RESET = 16'h0000;
  localparam logic BURST_RESET = 1'b0;

  // Shared-address read drive masks.
  localparam logic [7:0] MASK_AT = 8'h80;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;

  typedef enum logic [0:0] {
    CGL_RUN = 1'b0,
    CGL_CFG = 1'b1
  } cgl_cfg_state_t;

  typedef enum logic [1:0] {
    CGL_FDC_AT = 2'b00,
    CGL_FDC_PS = 2'b01,
    CGL_FDC_M30 = 2'b10
  } cgl_fdc_mode_t;

  typedef enum logic [2:0] {
    CGL_RATE_1M = 3'b000,
    CGL_RATE_500 = 3'b001,
    CGL_RATE_300 = 3'b010,
    CGL_RATE_250 = 3'b011,
    CGL_RATE_2M = 3'b100
  } cgl_rate_t;

  typedef struct packed {
    logic act;
    logic [15:0] base;
    logic [3:0] irq;
    logic [2:0] dma;
  } cgl_ld_cfg_t;

  typedef struct packed {
    logic precomp_disable;
    logic rate_table_sel_hi;
    logic rate_table_sel_lo;
    logic drive_type_sel_a;
    logic drive_type_sel_b;
  } cgl_drive_cfg_t;

  typedef struct packed {
    logic precomp_disable;
    logic density_level;
    logic rate_code_hi;
    logic rate_code_lo;
    logic drive_density_pin_a;
    logic drive_density_pin_b;
    cgl_rate_t rate;
  } cgl_drive_out_t;

  typedef struct packed {
    cgl_cfg_state_t st;
    logic [3:0] key_cnt;
    logic [7:0] idx;
    logic [7:0] ldn;
    cgl_ld_cfg_t [3:0] ld;
    cgl_drive_cfg_t [1:0] drv;
    logic burst_en;
    logic [7:0] rdata;
    logic rdata_oe_n;
    logic [7:0] echo;
    cgl_drive_out_t dout;
  } cgl_state_t;

endpackage

/* File: hw/cgl_reset_filter.sv */
// Synchroniser and qualification counter for the active-high system reset.
`timescale 1ns/1ps
`default_nettype none
module cgl_reset_filter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Raw and filtered reset
  input wire logic system_reset_in,
  output logic reset_filt
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic filt;
  } cgl_filt_state_t;

  cgl_filt_state_t st_r;
  cgl_filt_state_t st_nxt;

  // A pulse shorter than the qualification window never reaches the core.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = system_reset_in;
    st_nxt.s2 = st_r.s1;
    if (!st_r.s2) begin
      st_nxt.cnt = 8'h00;
      st_nxt.filt = 1'b0;
    end else if (st_r.cnt >= cgl_pkg::RESET_FILT_CYCLES - 8'h01) begin
      st_nxt.filt = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reset_filt = st_r.filt;

endmodule
`default_nettype wire

/* File: hw/cgl_top.sv */
// Configuration state machine, drive-rate mapping and IRQ/DMA gating glue.
`timescale 1ns/1ps
`default_nettype none
module cgl_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic system_reset_in,
  // Host I/O port access
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe_n,
  // Shared address arbitration
  input wire logic [1:0] fdc_mode,
  output logic [7:0] fdc_shared_rd_mask,
  output logic ide_decode_allow,
  // Floppy drive rate
  input wire logic drive_sel,
  input wire logic [1:0] rate_sel,
  output logic precomp_disable,
  output logic density_level,
  output logic rate_code_hi,
  output logic rate_code_lo,
  output logic drive_density_pin_a,
  output logic drive_density_pin_b,
  output logic [2:0] fdc_data_rate,
  output logic fdc_dma_burst_en,
  // Floppy IRQ and DMA
  input wire logic fdc_irq_req,
  input wire logic fdc_dreq,
  input wire logic floppy_dma_gate,
  input wire logic fdc_powerdown,
  input wire logic fdc_dack_n_in,
  output logic fdc_irq_out,
  output logic fdc_irq_oe_n,
  output logic fdc_drq_out,
  output logic fdc_drq_oe_n,
  output logic fdc_dack_n_gated,
  // Serial port interrupts
  input wire logic [1:0] uart_irq_req,
  input wire logic [1:0] uart_irq_gate,
  output logic [1:0] uart_irq_out,
  output logic [1:0] uart_irq_oe_n,
  // Parallel port
  input wire logic lpt_irq_req,
  input wire logic lpt_irq_enable,
  input wire logic lpt_ecp_active,
  input wire logic [2:0] lpt_ecr_mode,
  input wire logic lpt_transfer_request,
  input wire logic ecp_transfer_req_enable,
  input wire logic lpt_dack_n_in,
  output logic lpt_irq_out,
  output logic lpt_irq_oe_n,
  output logic lpt_drq_out,
  output logic lpt_drq_oe_n,
  output logic lpt_dack_n_gated,
  output logic [7:0] lpt_resource_echo,
  // Status
  output logic cfg_mode
);

  localparam logic [1:0] SLOT_FDC = 2'd0;
  localparam logic [1:0] SLOT_UART1 = 2'd1;
  localparam logic [1:0] SLOT_UART2 = 2'd2;
  localparam logic [1:0] SLOT_LPT = 2'd3;

  cgl_pkg::cgl_state_t st_r;
  cgl_pkg::cgl_state_t st_nxt;
  logic reset_filt;

  cgl_reset_filter u_filt (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .system_reset_in(system_reset_in),
    .reset_filt(reset_filt)
  );

  // Maps a logical device number onto a configuration slot.
  function automatic logic [2:0] ld_slot(input logic [7:0] ldn);
    case (ldn)
      cgl_pkg::LDN_FDC: ld_slot = {1'b1, SLOT_FDC};
      cgl_pkg::LDN_UART1: ld_slot = {1'b1, SLOT_UART1};
      cgl_pkg::LDN_UART2: ld_slot = {1'b1, SLOT_UART2};
      cgl_pkg::LDN_LPT: ld_slot = {1'b1, SLOT_LPT};
      default: ld_slot = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] irq_code(input logic [3:0] irq);
    case (irq)
      4'hF: irq_code = 3'h6;
      4'hE: irq_code = 3'h5;
      4'hB: irq_code = 3'h4;
      4'hA: irq_code = 3'h3;
      4'h9: irq_code = 3'h2;
      4'h7: irq_code = 3'h1;
      4'h5: irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] dma_code(input logic [2:0] dma);
    case (dma)
      3'h3: dma_code = 3'h3;
      3'h2: dma_code = 3'h2;
      3'h1: dma_code = 3'h1;
      default: dma_code = 3'h0;
    endcase
  endfunction

  // A device takes part only when active and given a nonzero base.
  function automatic logic ld_live(input cgl_pkg::cgl_ld_cfg_t c);
    ld_live = c.act && (c.base != cgl_pkg::BASE_RESET);
  endfunction

  function automatic cgl_pkg::cgl_drive_cfg_t drv_from_byte(input logic [7:0] b);
    drv_from_byte.precomp_disable = b[cgl_pkg::DRV_PRECOMP_BIT];
    drv_from_byte.rate_table_sel_hi = b[cgl_pkg::DRV_TABLE_HI_BIT];
    drv_from_byte.rate_table_sel_lo = b[cgl_pkg::DRV_TABLE_LO_BIT];
    drv_from_byte.drive_type_sel_a = b[cgl_pkg::DRV_TYPE_A_BIT];
    drv_from_byte.drive_type_sel_b = b[cgl_pkg::DRV_TYPE_B_BIT];
  endfunction

  function automatic logic [7:0] drv_to_byte(input cgl_pkg::cgl_drive_cfg_t d);
    drv_to_byte = 8'h00;
    drv_to_byte[cgl_pkg::DRV_PRECOMP_BIT] = d.precomp_disable;
    drv_to_byte[cgl_pkg::DRV_TABLE_HI_BIT] = d.rate_table_sel_hi;
    drv_to_byte[cgl_pkg::DRV_TABLE_LO_BIT] = d.rate_table_sel_lo;
    drv_to_byte[cgl_pkg::DRV_TYPE_A_BIT] = d.drive_type_sel_a;
    drv_to_byte[cgl_pkg::DRV_TYPE_B_BIT] = d.drive_type_sel_b;
  endfunction

  function automatic cgl_pkg::cgl_state_t reset_state();
    reset_state = '0;
    reset_state.st = cgl_pkg::CGL_RUN;
    reset_state.rdata_oe_n = 1'b1;
    reset_state.burst_en = cgl_pkg::BURST_RESET;
    for (int i = 0; i < 4; i++) begin
      reset_state.ld[i].act = 1'b0;
      reset_state.ld[i].base = cgl_pkg::BASE_RESET;
      reset_state.ld[i].irq = cgl_pkg::IRQ_RESET;
      reset_state.ld[i].dma = cgl_pkg::DMA_NONE;
    end
  endfunction

  function automatic logic [7:0] read_reg(input cgl_pkg::cgl_state_t s);
    logic [2:0] sl;
    sl = ld_slot(s.ldn);
    read_reg = 8'h00;
    case (s.idx)
      cgl_pkg::IDX_LDN: read_reg = s.ldn;
      cgl_pkg::IDX_DRIVE0_RATE_TYPE_CFG: read_reg = (s.ldn == cgl_pkg::LDN_FDC) ? drv_to_byte(s.drv[0]) : 8'h00;
      cgl_pkg::IDX_DRIVE1_RATE_TYPE_CFG: read_reg = (s.ldn == cgl_pkg::LDN_FDC) ? drv_to_byte(s.drv[1]) : 8'h00;
      cgl_pkg::IDX_FDC_OPT: begin
        if (s.ldn == cgl_pkg::LDN_FDC) begin
          read_reg[cgl_pkg::FDC_OPT_BURST_BIT] = s.burst_en;
        end
      end
      cgl_pkg::IDX_ACT: read_reg = sl[2] ? {7'h00, s.ld[sl[1:0]].act} : 8'h00;
      cgl_pkg::IDX_BASE_HI: read_reg = sl[2] ? s.ld[sl[1:0]].base[15:8] : 8'h00;
      cgl_pkg::IDX_BASE_LO: read_reg = sl[2] ? s.ld[sl[1:0]].base[7:0] : 8'h00;
      cgl_pkg::IDX_IRQ: read_reg = sl[2] ? {4'h0, s.ld[sl[1:0]].irq} : 8'h00;
      cgl_pkg::IDX_DMA: read_reg = sl[2] ? {5'h00, s.ld[sl[1:0]].dma} : 8'h00;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Applies the rate table to the given drive's settings and routes the density pins.
  function automatic cgl_pkg::cgl_drive_out_t drive_map(input cgl_pkg::cgl_drive_cfg_t d, input logic [1:0] rs);
    logic dens;
    logic [1:0] tbl;
    dens = (rs == 2'b11) || (rs == 2'b00);
    tbl = {d.rate_table_sel_hi, d.rate_table_sel_lo};
    drive_map.precomp_disable = d.precomp_disable;
    drive_map.density_level = dens;
    drive_map.rate_code_hi = rs[1];
    drive_map.rate_code_lo = rs[0];
    case (rs)
      2'b11: drive_map.rate = cgl_pkg::CGL_RATE_1M;
      2'b00: drive_map.rate = cgl_pkg::CGL_RATE_500;
      2'b10: drive_map.rate = cgl_pkg::CGL_RATE_250;
      default: begin
        // Table 11 is undefined and behaves as the regular table.
        case (tbl)
          2'b01: drive_map.rate = cgl_pkg::CGL_RATE_500;
          2'b10: drive_map.rate = cgl_pkg::CGL_RATE_2M;
          default: drive_map.rate = cgl_pkg::CGL_RATE_300;
        endcase
      end
    endcase
    case ({d.drive_type_sel_a, d.drive_type_sel_b})
      2'b00: begin
        drive_map.drive_density_pin_a = dens;
        drive_map.drive_density_pin_b = rs[0];
      end
      2'b01: begin
        drive_map.drive_density_pin_a = rs[1];
        drive_map.drive_density_pin_b = rs[0];
      end
      2'b10: begin
        drive_map.drive_density_pin_a = ~dens;
        drive_map.drive_density_pin_b = rs[0];
      end
      default: begin
        drive_map.drive_density_pin_a = rs[0];
        drive_map.drive_density_pin_b = rs[1];
      end
    endcase
  endfunction

  always_comb begin
    logic [2:0] sl;
    logic cfg_wr;
    logic data_wr;
    sl = ld_slot(st_r.ldn);
    cfg_wr = io_wr && (io_addr == cgl_pkg::CFG_PORT_ADDR);
    data_wr = io_wr && (io_addr == cgl_pkg::DATA_PORT_ADDR);
    st_nxt = st_r;
    st_nxt.rdata_oe_n = 1'b1;
    st_nxt.rdata = 8'h00;
    case (st_r.st)
      cgl_pkg::CGL_RUN: begin
        if (cfg_wr) begin
          if (io_wdata != cgl_pkg::KEY_BYTE) begin
            st_nxt.key_cnt = 4'h0;
          end else if (st_r.key_cnt == cgl_pkg::KEY_LEN - 4'h1) begin
            st_nxt.key_cnt = 4'h0;
            st_nxt.st = cgl_pkg::CGL_CFG;
          end else begin
            st_nxt.key_cnt = st_r.key_cnt + 4'h1;
          end
        end
      end
      cgl_pkg::CGL_CFG: begin
        if (cfg_wr) begin
          if (io_wdata == cgl_pkg::EXIT_BYTE) begin
            st_nxt.st = cgl_pkg::CGL_RUN;
          end else begin
            st_nxt.idx = io_wdata;
          end
        end else if (data_wr) begin
          case (st_r.idx)
            cgl_pkg::IDX_LDN: st_nxt.ldn = io_wdata;
            cgl_pkg::IDX_DRIVE0_RATE_TYPE_CFG: begin
              if (st_r.ldn == cgl_pkg::LDN_FDC) begin
                st_nxt.drv[0] = drv_from_byte(io_wdata);
              end
            end
            cgl_pkg::IDX_DRIVE1_RATE_TYPE_CFG: begin
              if (st_r.ldn == cgl_pkg::LDN_FDC) begin
                st_nxt.drv[1] = drv_from_byte(io_wdata);
              end
            end
            cgl_pkg::IDX_FDC_OPT: begin
              if (st_r.ldn == cgl_pkg::LDN_FDC) begin
                st_nxt.burst_en = io_wdata[cgl_pkg::FDC_OPT_BURST_BIT];
              end
            end
            cgl_pkg::IDX_ACT: if (sl[2]) st_nxt.ld[sl[1:0]].act = io_wdata[0];
            cgl_pkg::IDX_BASE_HI: if (sl[2]) st_nxt.ld[sl[1:0]].base[15:8] = io_wdata;
            cgl_pkg::IDX_BASE_LO: if (sl[2]) st_nxt.ld[sl[1:0]].base[7:0] = io_wdata;
            cgl_pkg::IDX_IRQ: if (sl[2]) st_nxt.ld[sl[1:0]].irq = io_wdata[3:0];
            cgl_pkg::IDX_DMA: if (sl[2]) st_nxt.ld[sl[1:0]].dma = io_wdata[2:0];
            default: st_nxt.idx = st_r.idx;
          endcase
        end else if (io_rd && (io_addr == cgl_pkg::CFG_PORT_ADDR)) begin
          st_nxt.rdata = st_r.idx;
          st_nxt.rdata_oe_n = 1'b0;
        end else if (io_rd && (io_addr == cgl_pkg::DATA_PORT_ADDR)) begin
          st_nxt.rdata = read_reg(st_r);
          st_nxt.rdata_oe_n = 1'b0;
        end
      end
      default: st_nxt.st = cgl_pkg::CGL_RUN;
    endcase
    st_nxt.echo = {2'b00, irq_code(st_r.ld[SLOT_LPT].irq), dma_code(st_r.ld[SLOT_LPT].dma)};
    st_nxt.dout = drive_map(st_r.drv[drive_sel], rate_sel);
    if (reset_filt) begin
      st_nxt = reset_state();
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.rdata_oe_n <= 1'b1;
      st_r.ld[0].dma <= cgl_pkg::DMA_NONE;
      st_r.ld[1].dma <= cgl_pkg::DMA_NONE;
      st_r.ld[2].dma <= cgl_pkg::DMA_NONE;
      st_r.ld[3].dma <= cgl_pkg::DMA_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign io_rdata = st_r.rdata;
  assign io_rdata_oe_n = st_r.rdata_oe_n;
  assign cfg_mode = (st_r.st == cgl_pkg::CGL_CFG);
  assign lpt_resource_echo = st_r.echo;
  assign fdc_dma_burst_en = st_r.burst_en;
  assign precomp_disable = st_r.dout.precomp_disable;
  assign density_level = st_r.dout.density_level;
  assign rate_code_hi = st_r.dout.rate_code_hi;
  assign rate_code_lo = st_r.dout.rate_code_lo;
  assign drive_density_pin_a = st_r.dout.drive_density_pin_a;
  assign drive_density_pin_b = st_r.dout.drive_density_pin_b;
  assign fdc_data_rate = st_r.dout.rate;

  // The floppy answers the shared address alone; IDE never decodes it.
  assign ide_decode_allow = (io_addr != cgl_pkg::SHARED_ADDR);
  always_comb begin
    fdc_shared_rd_mask = cgl_pkg::MASK_NONE;
    if (io_rd && (io_addr == cgl_pkg::SHARED_ADDR) && ld_live(st_r.ld[SLOT_FDC])) begin
      fdc_shared_rd_mask = (fdc_mode == cgl_pkg::CGL_FDC_AT) ? cgl_pkg::MASK_AT : cgl_pkg::MASK_ALL;
    end
  end

  // Gating is combinational so a disable floats the pin in the same cycle.
  logic fdc_en;
  logic lpt_irq_on;
  logic lpt_drq_on;
  assign fdc_en = ld_live(st_r.ld[SLOT_FDC]) && floppy_dma_gate && !fdc_powerdown;
  assign fdc_irq_out = fdc_irq_req;
  assign fdc_irq_oe_n = !fdc_en;
  assign fdc_drq_out = fdc_dreq && fdc_en;
  assign fdc_drq_oe_n = !fdc_en;
  assign fdc_dack_n_gated = fdc_dack_n_in || !fdc_en;

  assign uart_irq_out = uart_irq_req;
  assign uart_irq_oe_n[0] = !(ld_live(st_r.ld[SLOT_UART1]) && uart_irq_gate[0]);
  assign uart_irq_oe_n[1] = !(ld_live(st_r.ld[SLOT_UART2]) && uart_irq_gate[1]);

  always_comb begin
    lpt_irq_on = lpt_irq_enable;
    lpt_drq_on = 1'b0;
    if (lpt_ecp_active) begin
      lpt_drq_on = ecp_transfer_req_enable;
      case (lpt_ecr_mode)
        3'b010, 3'b011, 3'b110: lpt_irq_on = 1'b1;
        default: lpt_irq_on = lpt_irq_enable;
      endcase
    end
    lpt_irq_on = lpt_irq_on && ld_live(st_r.ld[SLOT_LPT]);
    lpt_drq_on = lpt_drq_on && ld_live(st_r.ld[SLOT_LPT]);
  end
  assign lpt_irq_out = lpt_irq_req;
  assign lpt_irq_oe_n = !lpt_irq_on;
  assign lpt_drq_out = lpt_transfer_request && lpt_drq_on;
  assign lpt_drq_oe_n = !lpt_drq_on;
  assign lpt_dack_n_gated = lpt_dack_n_in || !lpt_drq_on;

endmodule
`default_nettype wire

/* File: verification/cgl_monitor.sv */
// Concurrent checks on the ports of the configuration glue.
`timescale 1ns/1ps
`default_nettype none
module cgl_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic system_reset_in,
  // Host access
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic io_rdata_oe_n,
  input wire logic cfg_mode,
  // Shared address
  input wire logic [1:0] fdc_mode,
  input wire logic [7:0] fdc_shared_rd_mask,
  input wire logic ide_decode_allow,
  // Gating
  input wire logic floppy_dma_gate,
  input wire logic fdc_powerdown,
  input wire logic fdc_irq_oe_n,
  input wire logic fdc_drq_oe_n,
  input wire logic [1:0] uart_irq_gate,
  input wire logic [1:0] uart_irq_oe_n,
  input wire logic lpt_ecp_active,
  input wire logic ecp_transfer_req_enable,
  input wire logic lpt_drq_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic key_w;
  logic cfg_w;
  assign cfg_w = io_wr && io_addr == cgl_pkg::CFG_PORT_ADDR;
  assign key_w = cfg_w && io_wdata == cgl_pkg::KEY_BYTE;
  a_key_entry: assert property (!cfg_mode && key_w ##1 key_w |=> cfg_mode) else $error("key not taken");
  a_exit_run: assert property (cfg_w && io_wdata == cgl_pkg::EXIT_BYTE |=> !cfg_mode) else $error("no exit");
  a_read_answer: assert property (cfg_mode && io_rd && !io_wr && io_addr == cgl_pkg::DATA_PORT_ADDR
    |=> !io_rdata_oe_n) else $error("read unanswered");
  a_run_silent: assert property (!cfg_mode && io_rd && !io_wr |=> io_rdata_oe_n) else $error("run read answered");
  a_ide_block: assert property (io_addr == cgl_pkg::SHARED_ADDR |-> !ide_decode_allow) else $error("ide decode");
  a_shared_mask: assert property (fdc_shared_rd_mask != 8'h00
    |-> fdc_shared_rd_mask == (fdc_mode == 2'h0 ? 8'h80 : 8'hFF)) else $error("shared mask");
  a_fdc_float: assert property (!floppy_dma_gate || fdc_powerdown |-> fdc_irq_oe_n && fdc_drq_oe_n)
    else $error("floppy driving");
  a_uart_float: assert property ((~uart_irq_gate & ~uart_irq_oe_n) == 2'h0) else $error("serial driving");
  a_ecp_drq: assert property (lpt_ecp_active && !ecp_transfer_req_enable |-> lpt_drq_oe_n)
    else $error("ecp request");
  a_filter_reset: assert property (system_reset_in [*8] ##1 system_reset_in [*7] |=> !cfg_mode)
    else $error("reset ignored");
  c_enter: cover property (!cfg_mode ##1 cfg_mode);
  c_read: cover property (!io_rdata_oe_n);
  c_sysrst: cover property (cfg_mode ##1 system_reset_in [*8]);
endmodule
bind cgl_top cgl_monitor i_mon (.*);
`default_nettype wire

/* File: verification/cgl_host.sv */
// Host model that drives the configuration and data ports.
`timescale 1ns/1ps
`default_nettype none
module cgl_host (
  // Clock
  input wire logic clk_sys,
  // Host I/O
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_oe_n
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // A write strobe is held over back-to-back calls until idle, park or rd lowers it.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_rd <= 1'b0;
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic idle();
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    io_wdata <= ~io_wdata;
    @(posedge clk_sys);
  endtask
  // The shared-address mask only shows while a read is in flight, so the read is held.
  task automatic park(input logic [15:0] a);
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk_sys);
  endtask
  // The answer stands for one cycle only, so it is taken inside that cycle.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ans);
    io_wr <= 1'b0;
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    #1;
    d = io_rdata;
    ans = !io_rdata_oe_n;
    @(posedge clk_sys);
  endtask
  task automatic enter();
    for (int i = 0; i < cgl_pkg::KEY_LEN; i++) wr(cgl_pkg::CFG_PORT_ADDR, cgl_pkg::KEY_BYTE);
    idle();
  endtask
  task automatic leave();
    wr(cgl_pkg::CFG_PORT_ADDR, cgl_pkg::EXIT_BYTE);
    idle();
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(cgl_pkg::CFG_PORT_ADDR, i);
    wr(cgl_pkg::DATA_PORT_ADDR, d);
    idle();
  endtask
  task automatic reg_rd(input logic [7:0] i, output logic [7:0] d, output logic ans);
    wr(cgl_pkg::CFG_PORT_ADDR, i);
    rd(cgl_pkg::DATA_PORT_ADDR, d, ans);
  endtask
endmodule
`default_nettype wire

/* File: verification/cgl_top_test.sv */
// Self-checking bench for the configuration glue.
`timescale 1ns/1ps
`default_nettype none
module cgl_top_test;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic system_reset_in = 1'b0, drive_sel = 1'b0, fdc_irq_req = 1'b0, floppy_dma_gate = 1'b0;
  logic fdc_powerdown = 1'b0, lpt_irq_req = 1'b0, lpt_irq_enable = 1'b0, lpt_ecp_active = 1'b0;
  logic ecp_transfer_req_enable = 1'b0;
  logic [1:0] fdc_mode = 2'h0, rate_sel = 2'h0, uart_irq_req = 2'h3, uart_irq_gate = 2'h0;
  logic [2:0] lpt_ecr_mode = 3'h0;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, fdc_shared_rd_mask, lpt_resource_echo;
  logic io_wr, io_rd, io_rdata_oe_n, ide_decode_allow, precomp_disable, density_level, rate_code_hi;
  logic rate_code_lo, drive_density_pin_a, drive_density_pin_b, fdc_dma_burst_en, fdc_irq_out, fdc_irq_oe_n;
  logic fdc_drq_out, fdc_drq_oe_n, fdc_dack_n_gated, lpt_irq_out, lpt_irq_oe_n, lpt_drq_out, lpt_drq_oe_n;
  logic lpt_dack_n_gated, cfg_mode;
  logic [2:0] fdc_data_rate;
  logic [1:0] uart_irq_out, uart_irq_oe_n;
  int miscompares = 0;
  int checked = 0;
  always #20 clk_sys = ~clk_sys;
  cgl_host i_host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rdata_oe_n(io_rdata_oe_n));
  // Request and acknowledge inputs are tied so the gating is visible on the outputs.
  cgl_top i_dut (.*, .fdc_dreq(1'b1), .fdc_dack_n_in(1'b0), .lpt_transfer_request(1'b1), .lpt_dack_n_in(1'b0));
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_cfg(input logic e);
    for (int n = 0; n < 8 && cfg_mode !== e; n++) settle(1);
    chk(cfg_mode, e);
    if (cfg_mode !== e) final_report();
  endtask
  task automatic ld_on(input logic [7:0] n, input logic [7:0] hi, input logic [7:0] lo);
    i_host.reg_wr(cgl_pkg::IDX_LDN, n);
    i_host.reg_wr(cgl_pkg::IDX_BASE_HI, hi);
    i_host.reg_wr(cgl_pkg::IDX_BASE_LO, lo);
    i_host.reg_wr(cgl_pkg::IDX_ACT, 8'h01);
  endtask
  function automatic logic [2:0] irq_code(input int k);
    case (k)
      15: return 3'h6;
      14: return 3'h5;
      11: return 3'h4;
      10: return 3'h3;
      9: return 3'h2;
      7: return 3'h1;
      5: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  initial begin
    logic [7:0] d;
    logic a, den;
    logic [2:0] rt;
    logic [1:0] pn;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    settle(2);
    chk({cfg_mode, lpt_resource_echo, fdc_dma_burst_en}, 16'h0000);
    chk({fdc_irq_oe_n, lpt_irq_oe_n, uart_irq_oe_n}, 16'h000F);
    i_host.rd(cgl_pkg::DATA_PORT_ADDR, d, a);
    chk(a, 16'h0000);
    i_host.wr(cgl_pkg::CFG_PORT_ADDR, cgl_pkg::KEY_BYTE);
    i_host.wr(cgl_pkg::CFG_PORT_ADDR, 8'h12);
    i_host.wr(cgl_pkg::CFG_PORT_ADDR, cgl_pkg::KEY_BYTE);
    i_host.idle();
    settle(1);
    chk(cfg_mode, 16'h0000);
    i_host.enter();
    wait_cfg(1'b1);
    i_host.reg_wr(cgl_pkg::IDX_LDN, cgl_pkg::LDN_FDC);
    i_host.reg_wr(cgl_pkg::IDX_DRIVE0_RATE_TYPE_CFG, 8'hFF);
    i_host.reg_rd(cgl_pkg::IDX_DRIVE0_RATE_TYPE_CFG, d, a);
    chk({a, d}, 16'h015B);
    for (int t = 0; t < 3; t++) begin
      for (int dt = 0; dt < 4; dt++) begin
        i_host.reg_wr(cgl_pkg::IDX_DRIVE0_RATE_TYPE_CFG, 8'(t * 8 + dt));
        for (int r = 0; r < 4; r++) begin
          rate_sel <= 2'(r);
          settle(2);
          den = (r == 0 || r == 3);
          rt = r == 3 ? 3'h0 : r == 0 ? 3'h1 : r == 2 ? 3'h3 : t == 0 ? 3'h2 : t == 1 ? 3'h1 : 3'h4;
          pn = dt == 0 ? {den, r[0]} : dt == 1 ? 2'(r) : dt == 2 ? {~den, r[0]} : {r[0], r[1]};
          chk({precomp_disable, density_level, rate_code_hi, rate_code_lo, drive_density_pin_a,
            drive_density_pin_b, fdc_data_rate}, {7'h0, den, 2'(r), pn, rt});
        end
      end
    end
    i_host.reg_wr(cgl_pkg::IDX_DRIVE1_RATE_TYPE_CFG, 8'h40);
    drive_sel <= 1'b1;
    settle(2);
    chk(precomp_disable, 16'h0001);
    i_host.reg_wr(cgl_pkg::IDX_FDC_OPT, 8'h02);
    settle(1);
    chk(fdc_dma_burst_en, 16'h0001);
    i_host.reg_wr(cgl_pkg::IDX_LDN, cgl_pkg::LDN_LPT);
    for (int k = 0; k < 16; k++) begin
      i_host.reg_wr(cgl_pkg::IDX_IRQ, 8'(k));
      settle(1);
      chk(lpt_resource_echo, {10'h0, irq_code(k), 3'h0});
    end
    i_host.reg_wr(cgl_pkg::IDX_IRQ, 8'h00);
    for (int k = 0; k < 5; k++) begin
      i_host.reg_wr(cgl_pkg::IDX_DMA, 8'(k));
      settle(1);
      chk(lpt_resource_echo, (k > 0 && k < 4) ? 16'(k) : 16'h0000);
    end
    lpt_irq_req <= 1'b1;
    lpt_irq_enable <= 1'b1;
    settle(1);
    chk(lpt_irq_oe_n, 16'h0001);
    ld_on(cgl_pkg::LDN_LPT, 8'h03, 8'h78);
    settle(1);
    chk({lpt_irq_oe_n, lpt_irq_out}, 16'h0001);
    lpt_irq_enable <= 1'b0;
    settle(1);
    chk(lpt_irq_oe_n, 16'h0001);
    lpt_ecp_active <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      lpt_ecr_mode <= 3'(m);
      ecp_transfer_req_enable <= m[0];
      settle(1);
      chk({lpt_irq_oe_n, lpt_drq_oe_n}, {14'h0, !(m == 2 || m == 3 || m == 6), !m[0]});
    end
    ld_on(cgl_pkg::LDN_UART1, 8'h03, 8'hF8);
    uart_irq_gate <= 2'h1;
    settle(1);
    chk({uart_irq_oe_n, uart_irq_out[0]}, 16'h0005);
    uart_irq_gate <= 2'h0;
    settle(1);
    chk(uart_irq_oe_n, 16'h0003);
    ld_on(cgl_pkg::LDN_FDC, 8'h03, 8'hF0);
    floppy_dma_gate <= 1'b1;
    fdc_irq_req <= 1'b1;
    settle(1);
    chk({fdc_irq_oe_n, fdc_irq_out}, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      floppy_dma_gate <= k[0];
      fdc_powerdown <= k[0];
      settle(1);
      chk({fdc_irq_oe_n, fdc_drq_oe_n, fdc_dack_n_gated}, 16'h0007);
    end
    fdc_powerdown <= 1'b0;
    floppy_dma_gate <= 1'b1;
    i_host.park(cgl_pkg::SHARED_ADDR);
    for (int m = 0; m < 3; m++) begin
      fdc_mode <= 2'(m);
      settle(1);
      chk({ide_decode_allow, fdc_shared_rd_mask}, m == 0 ? 16'h0080 : 16'h00FF);
    end
    i_host.leave();
    wait_cfg(1'b0);
    i_host.rd(cgl_pkg::DATA_PORT_ADDR, d, a);
    chk(a, 16'h0000);
    i_host.enter();
    wait_cfg(1'b1);
    // A short pulse must be filtered out, a long one must reset everything.
    system_reset_in <= 1'b1;
    settle(4);
    system_reset_in <= 1'b0;
    settle(6);
    chk(cfg_mode, 16'h0001);
    system_reset_in <= 1'b1;
    settle(16);
    chk({cfg_mode, lpt_resource_echo, fdc_irq_oe_n}, 16'h0001);
    system_reset_in <= 1'b0;
    settle(4);
    i_host.enter();
    wait_cfg(1'b1);
    i_host.reg_rd(cgl_pkg::IDX_DRIVE0_RATE_TYPE_CFG, d, a);
    chk({a, d}, 16'h0100);
    final_report();
  end
endmodule
`default_nettype wire
